/* File: mrs_reset_ctrl.sv */
// Purpose: reset source control with register images over AXI4-Lite
// Assumes: all inputs synchronous to sys_clk; nrst is power-on reset
// Notes: image registers are the reset-sensitive core and peripheral set
//
// What this block does
// RULE1: outside hardware pulls the active-low clear pin low to reset.
// RULE2: a pin reset, like every reset, clears the program counter.
// RULE3: droop reset and trip level are options; disabled means no reset.
// RULE4: droop resets only when it lasts longer than the minimum time.
// RULE5: watchdog expiry while running acts as a pin reset, sets expired.
// RULE6: watchdog expiry in power-down clears only counter and stack.
// RULE7: expired and power-down flags live in status, set by events.
// RULE8: power-on clears both flags; pin or droop reset keeps them. In power-down the code clears expired and sets power-down.
// RULE9: running watchdog expiry sets expired, keeps power-down flag.
// RULE10: power-down watchdog expiry sets both flags.
// RULE11: reset disables every interrupt source.
// RULE12: reset reloads watchdog setup, except power-down watchdog expiry.
// RULE13: reset switches timers off by loading the timer control pattern.
// RULE14: reset sets port data and direction to all ones.
// RULE15: reset points the stack pointer to the stack top.
// RULE16: data registers are untouched; low program counter always clears.
// RULE17: power-down watchdog expiry keeps peripheral registers unchanged.
// RULE18: other resets load tone control default and clear tone value.
// RULE19: after the pin is released wait the start-up period first.
// RULE20: sources merge into one internal reset released on one edge.
`timescale 1ns/1ns
`include "mrs_regs.svh"

module mrs_reset_ctrl
   import mrs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic hwClearPinN,
   input wire logic supplyLow,
   input wire logic watchdogTimeout,
   input wire logic haltActive,
   input wire mrs_axi_req_t axiReq,
   output mrs_axi_rsp_t axiRsp,
   output logic sysRstN,
   output mrs_image_t regImage,
   output logic [1:0] droopTripThreshold,
   output mrs_cause_t resetCause
);

   mrs_ctl_t s;
   mrs_ctl_t next_s;
   logic droopHit;
   logic waitDone;
   logic startWait;
   logic pinLow;
   logic wdRun;
   logic wdSleep;
   logic wrFire;
   logic [31:0] wrVal;
   logic [31:0] rdVal;

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   function automatic mrs_image_t loadDefaults(input mrs_image_t cur);
      mrs_image_t r;
      r = cur;
      r.progCounterLow = `MRS_PCL_RST; // RULE16
      r.stackPtr = `MRS_SP_RST; // RULE15
      r.watchdogSetupReg = `MRS_WDSETUP_RST; // RULE12
      r.intCtl0 = `MRS_INTC0_RST; // RULE11
      r.intCtl1 = `MRS_INTC1_RST; // RULE11
      r.tmrCtl = `MRS_TMRC_RST; // RULE13
      r.portData = `MRS_PORT_RST; // RULE14
      r.portDir = `MRS_PORT_RST; // RULE14
      r.toneGenControl = `MRS_TONECTL_RST; // RULE18
      r.toneGenValue = `MRS_TONEVAL_RST; // RULE18
      return r;
   endfunction

   function automatic mrs_ctl_t resetState();
      mrs_ctl_t r;
      r = '0;
      r.phase = PH_WAIT;
      r.cause = CS_POWERON;
      r.droopEn = `MRS_CTRL_DROOPEN_RST;
      r.trip = `MRS_CTRL_TRIP_RST;
      r.img = loadDefaults('0);
      r.img.wdExpired = 1'b0; // RULE8
      r.img.powerdownFlag = 1'b0; // RULE8
      return r;
   endfunction

   function automatic logic [31:0] mergeStrb(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic isMapped(input logic [7:0] a);
      logic r;
      r = 1'b0;
      unique case (a)
         `MRS_CTRL_OFS, `MRS_STATUS_OFS, `MRS_WDSETUP_OFS, `MRS_INTC_OFS,
         `MRS_TMRC_OFS, `MRS_PORT_OFS, `MRS_TONE_OFS,
         `MRS_CORE_OFS: r = 1'b1;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   function automatic logic [31:0] readReg(input mrs_ctl_t c,
      input logic [7:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      unique case (a)
         `MRS_CTRL_OFS: begin
            r[`MRS_CTRL_DROOPEN_BIT] = c.droopEn;
            r[`MRS_CTRL_TRIP_LSB +: 2] = c.trip;
         end
         `MRS_STATUS_OFS: begin
            r[`MRS_ST_WDEXP_BIT] = c.img.wdExpired; // RULE7
            r[`MRS_ST_PDOWN_BIT] = c.img.powerdownFlag; // RULE7
            r[`MRS_ST_CAUSE_LSB +: 3] = c.cause;
            r[`MRS_ST_INRST_BIT] = !c.coreRun;
         end
         `MRS_WDSETUP_OFS: r[7:0] = c.img.watchdogSetupReg;
         `MRS_INTC_OFS: r[15:0] = {c.img.intCtl1, 1'b0, c.img.intCtl0};
         `MRS_TMRC_OFS: r[7:0] = c.img.tmrCtl;
         `MRS_PORT_OFS: r[15:0] = {c.img.portDir, c.img.portData};
         `MRS_TONE_OFS: begin
            r[15:0] = {c.img.toneGenValue, 5'h00, c.img.toneGenControl};
         end
         `MRS_CORE_OFS: r[10:0] = {c.img.stackPtr, c.img.progCounterLow};
         default: r = 32'h0000_0000;
      endcase
      return r;
   endfunction

   // ------------------------------------------------------------------
   // submodules
   // ------------------------------------------------------------------
   mrs_supply_droop_detector droopDet (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .enable(s.droopEn),
      .supplyLow(supplyLow),
      .qualified(droopHit)
   );

   mrs_startup_timer startTmr (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .start(startWait),
      .done(waitDone)
   );

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      next_s = s;
      startWait = 1'b0;
      pinLow = !hwClearPinN; // RULE1
      wdRun = (s.phase == PH_RUN) && watchdogTimeout && !haltActive
         && !pinLow && !droopHit;
      wdSleep = (s.phase == PH_RUN) && watchdogTimeout && haltActive
         && !pinLow && !droopHit;
      wrFire = s.awHave && s.wHave && !s.rsp.bvalid;
      wrVal = mergeStrb(readReg(s, s.waddr), s.wdata, s.wstrb);
      rdVal = readReg(s, axiReq.araddr);

      // write address and data channels
      next_s.rsp.awready = axiReq.awvalid && !s.rsp.awready && !s.awHave
         && !s.rsp.bvalid;
      next_s.rsp.wready = axiReq.wvalid && !s.rsp.wready && !s.wHave
         && !s.rsp.bvalid;
      if (axiReq.awvalid && s.rsp.awready) begin
         next_s.awHave = 1'b1;
         next_s.waddr = axiReq.awaddr;
      end
      if (axiReq.wvalid && s.rsp.wready) begin
         next_s.wHave = 1'b1;
         next_s.wdata = axiReq.wdata;
         next_s.wstrb = axiReq.wstrb;
      end
      if (s.rsp.bvalid && axiReq.bready) begin
         next_s.rsp.bvalid = 1'b0;
      end

      // register write
      if (wrFire) begin
         next_s.awHave = 1'b0;
         next_s.wHave = 1'b0;
         next_s.rsp.bvalid = 1'b1;
         next_s.rsp.bresp = isMapped(s.waddr) ? `MRS_RESP_OKAY
            : `MRS_RESP_SLVERR;
         unique case (s.waddr)
            `MRS_CTRL_OFS: begin
               next_s.droopEn = wrVal[`MRS_CTRL_DROOPEN_BIT]; // RULE3
               next_s.trip = wrVal[`MRS_CTRL_TRIP_LSB +: 2]; // RULE3
            end
            `MRS_STATUS_OFS: begin
               if (s.wstrb[0] && s.wdata[`MRS_ST_WDEXP_BIT]) begin
                  next_s.img.wdExpired = 1'b0;
               end
               if (s.wstrb[0] && s.wdata[`MRS_ST_PDOWN_BIT]) begin
                  next_s.img.powerdownFlag = 1'b0;
               end
            end
            `MRS_WDSETUP_OFS: next_s.img.watchdogSetupReg = wrVal[7:0];
            `MRS_INTC_OFS: begin
               next_s.img.intCtl0 = wrVal[6:0];
               next_s.img.intCtl1 = wrVal[15:8] & `MRS_INTC1_MASK;
            end
            `MRS_TMRC_OFS: next_s.img.tmrCtl = wrVal[7:0] & `MRS_TMRC_MASK;
            `MRS_PORT_OFS: begin
               next_s.img.portData = wrVal[7:0];
               next_s.img.portDir = wrVal[15:8];
            end
            `MRS_TONE_OFS: begin
               next_s.img.toneGenControl = wrVal[2:0] & `MRS_TONECTL_MASK;
               next_s.img.toneGenValue = wrVal[15:8];
            end
            default: next_s.rsp.bvalid = 1'b1;
         endcase
      end

      // read channel
      next_s.rsp.arready = axiReq.arvalid && !s.rsp.arready
         && !s.rsp.rvalid;
      if (axiReq.arvalid && s.rsp.arready) begin
         next_s.rsp.rvalid = 1'b1;
         next_s.rsp.rdata = rdVal;
         next_s.rsp.rresp = isMapped(axiReq.araddr) ? `MRS_RESP_OKAY
            : `MRS_RESP_SLVERR;
      end else if (s.rsp.rvalid && axiReq.rready) begin
         next_s.rsp.rvalid = 1'b0;
      end

      // power-down entry sets its flag over any clear
      next_s.haltSeen = haltActive;
      if (haltActive && !s.haltSeen) begin
         next_s.img.powerdownFlag = 1'b1; // RULE7
      end

      // reset sources
      if (pinLow || droopHit) begin
         if (s.phase != PH_HOLD) begin
            next_s.img = loadDefaults(next_s.img); // RULE2 RULE18
            next_s.cause = pinLow ? CS_PIN : CS_DROOP;
            if (haltActive) begin
               next_s.img.wdExpired = 1'b0;
               next_s.img.powerdownFlag = 1'b1;
            end
         end
         next_s.phase = PH_HOLD; // RULE20
         next_s.coreRun = 1'b0;
      end else begin
         unique case (s.phase)
            PH_RUN: begin
               if (wdRun) begin
                  next_s.img = loadDefaults(next_s.img); // RULE5 RULE12
                  next_s.img.wdExpired = 1'b1; // RULE9
                  next_s.cause = CS_WDRUN;
                  next_s.phase = PH_WAIT;
                  next_s.coreRun = 1'b0;
                  startWait = 1'b1;
               end else if (wdSleep) begin
                  next_s.img.progCounterLow = `MRS_PCL_RST; // RULE6
                  next_s.img.stackPtr = `MRS_SP_RST; // RULE6 RULE17
                  next_s.img.wdExpired = 1'b1; // RULE10
                  next_s.img.powerdownFlag = 1'b1; // RULE10
                  next_s.cause = CS_WDSLEEP;
                  next_s.phase = PH_WAIT;
                  next_s.coreRun = 1'b0;
                  startWait = 1'b1;
               end
            end
            PH_HOLD: begin
               next_s.phase = PH_WAIT; // RULE19
               startWait = 1'b1;
            end
            PH_WAIT: begin
               if (waitDone) begin
                  next_s.phase = PH_RUN; // RULE19 RULE20
                  next_s.coreRun = 1'b1;
               end
            end
            default: begin
               next_s.phase = PH_WAIT;
               next_s.coreRun = 1'b0;
               startWait = 1'b1;
            end
         endcase
      end

      // assertion helpers
      if (s.droopEn && supplyLow) begin
         if (s.aDroop != 6'h3F) begin
            next_s.aDroop = s.aDroop + 6'h01;
         end
      end else begin
         next_s.aDroop = 6'h00;
      end
      if (next_s.phase == PH_WAIT && s.phase != PH_WAIT) begin
         next_s.aWait = 11'h000;
      end else if (s.phase == PH_WAIT && s.aWait != 11'h7FF) begin
         next_s.aWait = s.aWait + 11'h001;
      end
   end

   // ------------------------------------------------------------------
   // state register and outputs
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         s <= resetState(); // RULE8 RULE20
      end else begin
         s <= next_s;
      end
   end

   assign axiRsp = s.rsp;
   assign sysRstN = s.coreRun;
   assign regImage = s.img;
   assign droopTripThreshold = s.trip;
   assign resetCause = s.cause;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);

   a_pcl_cleared: assert property ( // RULE2
      (s.phase != PH_HOLD && (pinLow || droopHit))
      |=> (s.img.progCounterLow == `MRS_PCL_RST && !sysRstN))
      else $error("program counter not cleared by pin reset");

   a_droop_disabled: assert property ( // RULE3
      (!s.droopEn) [*2] |-> !droopHit)
      else $error("droop reset while function disabled");

   a_droop_length: assert property ( // RULE4
      droopHit |-> (s.aDroop > 6'(`MRS_DROOP_MIN_CYC)))
      else $error("droop qualified too early");

   a_wd_running: assert property ( // RULE5 RULE9
      (wdRun && !wrFire) |=> (s.img.wdExpired && s.phase == PH_WAIT
      && s.img.watchdogSetupReg == `MRS_WDSETUP_RST
      && s.img.powerdownFlag == $past(s.img.powerdownFlag)))
      else $error("running watchdog reset wrong");

   a_wd_sleep: assert property ( // RULE6 RULE10
      wdSleep |=> (s.img.progCounterLow == `MRS_PCL_RST
      && s.img.stackPtr == `MRS_SP_RST && s.img.wdExpired
      && s.img.powerdownFlag && !sysRstN))
      else $error("power-down watchdog reset wrong");

   a_wd_sleep_keep: assert property ( // RULE17 RULE12
      (wdSleep && !wrFire) |=> ($stable(s.img.portData)
      && $stable(s.img.watchdogSetupReg) && $stable(s.img.tmrCtl)
      && $stable(s.img.toneGenValue) && $stable(s.img.intCtl0)))
      else $error("power-down watchdog reset changed peripherals");

   a_flags_kept: assert property ( // RULE8
      (s.phase != PH_HOLD && (pinLow || droopHit) && !haltActive
      && !wrFire) |=> ($stable(s.img.wdExpired)
      && $stable(s.img.powerdownFlag)))
      else $error("pin reset changed cause flags");

   a_defaults_load: assert property ( // RULE11 RULE13 RULE14 RULE15
      wdRun |=> (s.img.intCtl0 == `MRS_INTC0_RST
      && s.img.intCtl1 == `MRS_INTC1_RST && s.img.tmrCtl == `MRS_TMRC_RST
      && s.img.portData == `MRS_PORT_RST && s.img.portDir == `MRS_PORT_RST
      && s.img.stackPtr == `MRS_SP_RST
      && s.img.toneGenControl == `MRS_TONECTL_RST
      && s.img.toneGenValue == `MRS_TONEVAL_RST))
      else $error("defaults not loaded on reset"); // RULE18

   a_release_wait: assert property ( // RULE19 RULE20
      $rose(sysRstN) |-> (s.aWait >= 11'(`MRS_STARTUP_WAIT_CYC)))
      else $error("core released before start-up wait");

endmodule // mrs_reset_ctrl

/* File: mrs_regs.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 25 MHz system clock, 32-bit register words
// Notes: included by every design module file of the reset controller, not by the package
`ifndef MRS_REGS_SVH
`define MRS_REGS_SVH

// ---------------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------------
`define MRS_CTRL_OFS 8'h00
`define MRS_STATUS_OFS 8'h04
`define MRS_WDSETUP_OFS 8'h08
`define MRS_INTC_OFS 8'h0C
`define MRS_TMRC_OFS 8'h10
`define MRS_PORT_OFS 8'h14
`define MRS_TONE_OFS 8'h18
`define MRS_CORE_OFS 8'h1C

// ---------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------
`define MRS_CTRL_DROOPEN_BIT 0
`define MRS_CTRL_TRIP_LSB 1
`define MRS_ST_WDEXP_BIT 0
`define MRS_ST_PDOWN_BIT 1
`define MRS_ST_CAUSE_LSB 4
`define MRS_ST_INRST_BIT 8

// ---------------------------------------------------------------------
// reset values and masks
// ---------------------------------------------------------------------
`define MRS_CTRL_DROOPEN_RST 1'b1
`define MRS_CTRL_TRIP_RST 2'h0
`define MRS_PCL_RST 8'h00
`define MRS_SP_RST 3'h0
`define MRS_WDSETUP_RST 8'h07
`define MRS_INTC0_RST 7'h00
`define MRS_INTC1_RST 8'h00
`define MRS_INTC1_MASK 8'h77
`define MRS_TMRC_RST 8'h08
`define MRS_TMRC_MASK 8'hDF
`define MRS_PORT_RST 8'hFF
`define MRS_TONECTL_RST 3'h1
`define MRS_TONECTL_MASK 3'h5
`define MRS_TONEVAL_RST 8'h00
`define MRS_RESP_OKAY 2'h0
`define MRS_RESP_SLVERR 2'h2

// ---------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------
`define MRS_CLK_MHZ 25
`define MRS_CLK_PERIOD_NS (1000 / `MRS_CLK_MHZ)
`define MRS_STARTUP_WAIT_PERIOD_NS 40960
`define MRS_STARTUP_WAIT_CYC \
   ((`MRS_STARTUP_WAIT_PERIOD_NS + `MRS_CLK_PERIOD_NS - 1) \
   / `MRS_CLK_PERIOD_NS)
`define MRS_DROOP_MIN_DURATION_NS 1000
`define MRS_DROOP_MIN_CYC \
   ((`MRS_DROOP_MIN_DURATION_NS + `MRS_CLK_PERIOD_NS - 1) \
   / `MRS_CLK_PERIOD_NS)

`endif

/* File: mrs_pkg.sv */
// Purpose: types shared by the reset controller files
// Assumes: nothing beyond the register header
// Notes: all state of each module is one packed struct from here
package mrs_pkg;

   // ------------------------------------------------------------------
   // enumerations
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {PH_RUN, PH_HOLD, PH_WAIT} mrs_phase_t;
   typedef enum logic [2:0] {CS_POWERON, CS_PIN, CS_DROOP, CS_WDRUN,
      CS_WDSLEEP} mrs_cause_t;

   // ------------------------------------------------------------------
   // bus carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } mrs_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } mrs_axi_rsp_t;

   // ------------------------------------------------------------------
   // register images and module states
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] progCounterLow;
      logic [2:0] stackPtr;
      logic [7:0] watchdogSetupReg;
      logic [6:0] intCtl0;
      logic [7:0] intCtl1;
      logic [7:0] tmrCtl;
      logic [7:0] portData;
      logic [7:0] portDir;
      logic [2:0] toneGenControl;
      logic [7:0] toneGenValue;
      logic wdExpired;
      logic powerdownFlag;
   } mrs_image_t;

   typedef struct packed {
      logic [5:0] cnt;
      logic hit;
   } mrs_filt_t;

   typedef struct packed {
      logic [10:0] cnt;
      logic done;
   } mrs_timer_t;

   typedef struct packed {
      mrs_phase_t phase;
      mrs_cause_t cause;
      logic coreRun;
      logic haltSeen;
      logic droopEn;
      logic [1:0] trip;
      logic awHave;
      logic wHave;
      logic [7:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      mrs_image_t img;
      mrs_axi_rsp_t rsp;
      logic [5:0] aDroop;
      logic [10:0] aWait;
   } mrs_ctl_t;

endpackage

/* File: mrs_supply_droop_detector.sv */
// Purpose: qualifies a low-supply indication by its duration
// Assumes: supplyLow is synchronous to sys_clk
// Notes: hit only after the droop outlasts the minimum duration
`timescale 1ns/1ns
`include "mrs_regs.svh"

module mrs_supply_droop_detector
   import mrs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic enable,
   input wire logic supplyLow,
   output logic qualified
);

   mrs_filt_t s;
   mrs_filt_t next_s;

   // ------------------------------------------------------------------
   // duration counter
   // ------------------------------------------------------------------
   always_comb begin
      next_s = s;
      if (!enable || !supplyLow) begin
         next_s.cnt = 6'h00; // RULE3
         next_s.hit = 1'b0; // RULE4
      end else if (s.cnt == 6'(`MRS_DROOP_MIN_CYC)) begin
         next_s.hit = 1'b1; // RULE4
      end else begin
         next_s.cnt = s.cnt + 6'h01;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign qualified = s.hit;

endmodule // mrs_supply_droop_detector

/* File: mrs_startup_timer.sv */
// Purpose: counts the start-up wait after a reset is released
// Assumes: start is a one-cycle pulse
// Notes: starts counting when the synchronous reset is released
`timescale 1ns/1ns
`include "mrs_regs.svh"

module mrs_startup_timer
   import mrs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic start,
   output logic done
);

   mrs_timer_t s;
   mrs_timer_t next_s;

   // ------------------------------------------------------------------
   // down counter
   // ------------------------------------------------------------------
   always_comb begin
      next_s = s;
      if (start) begin
         next_s.cnt = 11'(`MRS_STARTUP_WAIT_CYC); // RULE19
         next_s.done = 1'b0;
      end else if (s.cnt != 11'h000) begin
         next_s.cnt = s.cnt - 11'h001;
         next_s.done = (s.cnt == 11'h001); // RULE19
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         s.cnt <= 11'(`MRS_STARTUP_WAIT_CYC);
         s.done <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   assign done = s.done;

endmodule // mrs_startup_timer

/* File: mrs_clear_supervisor.sv */
// Purpose: model of the outside clear switch and supply supervisor
// Assumes: bench calls press and droop right after a clock edge
// Notes: pin idles released high, supply idles good
`timescale 1ns/1ns
module mrs_clear_supervisor (
   input wire logic sys_clk,
   output logic hwClearPinN,
   output logic supplyLow
);
   initial begin
      hwClearPinN = 1'b1;
      supplyLow = 1'b0;
   end
   // pin pulled low for n edges
   task automatic press(input int n);
      @(posedge sys_clk);
      hwClearPinN <= 1'b0;
      repeat (n) @(posedge sys_clk);
      hwClearPinN <= 1'b1;
   endtask
   // supply low for n edges
   task automatic droop(input int n);
      @(posedge sys_clk);
      supplyLow <= 1'b1;
      repeat (n) @(posedge sys_clk);
      supplyLow <= 1'b0;
   endtask
endmodule // mrs_clear_supervisor

/* File: mrs_reset_ctrl_tb_top.sv */
// Purpose: bench for the reset source controller
// Assumes: 40 ns clock, AXI4-Lite master tasks
// Notes: supervisor model drives pin and droop
`timescale 1ns/1ns
`include "mrs_regs.svh"
module mrs_reset_ctrl_tb_top import mrs_pkg::*; ;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic wdTo = 1'b0;
   logic halt = 1'b0;
   mrs_axi_req_t axiReq = '0;
   mrs_axi_rsp_t axiRsp;
   logic sysRstN;
   mrs_image_t img;
   logic [1:0] trip;
   mrs_cause_t cause;
   logic pinN;
   logic low;
   logic [31:0] d;
   logic [1:0] r;
   int n;
   int cyc = 0;
   int mismatches = 0;
   int numChecks = 0;
   localparam logic [31:0] expA = {`MRS_PORT_RST, `MRS_PORT_RST,
      `MRS_TMRC_RST, `MRS_WDSETUP_RST};
   localparam logic [25:0] expB = {`MRS_TONECTL_RST, `MRS_TONEVAL_RST,
      `MRS_INTC0_RST, `MRS_INTC1_RST};
   wire [31:0] seenA = {img.portData, img.portDir, img.tmrCtl,
      img.watchdogSetupReg};
   wire [25:0] seenB = {img.toneGenControl, img.toneGenValue,
      img.intCtl0, img.intCtl1};
   wire [10:0] seenC = {img.progCounterLow, img.stackPtr};
   wire [1:0] flags = {img.wdExpired, img.powerdownFlag};
   always #20 sys_clk = ~sys_clk;
   mrs_clear_supervisor i_sup (.sys_clk(sys_clk), .hwClearPinN(pinN),
      .supplyLow(low));
   mrs_reset_ctrl i_dut (.sys_clk(sys_clk), .nrst(nrst),
      .hwClearPinN(pinN), .supplyLow(low), .watchdogTimeout(wdTo),
      .haltActive(halt), .axiReq(axiReq), .axiRsp(axiRsp),
      .sysRstN(sysRstN), .regImage(img), .droopTripThreshold(trip),
      .resetCause(cause));
   task automatic check(input string nm, input logic [31:0] s, e);
      numChecks++;
      if (s !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      axiReq.awvalid <= 1'b1;
      axiReq.awaddr <= a;
      axiReq.wvalid <= 1'b1;
      axiReq.wdata <= v;
      axiReq.wstrb <= 4'hF;
      axiReq.bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (axiRsp.awready) axiReq.awvalid <= 1'b0;
         if (axiRsp.wready) axiReq.wvalid <= 1'b0;
      end while (axiRsp.bvalid !== 1'b1);
      r = axiRsp.bresp;
      axiReq.bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      axiReq.arvalid <= 1'b1;
      axiReq.araddr <= a;
      axiReq.rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (axiRsp.arready) axiReq.arvalid <= 1'b0;
      end while (axiRsp.rvalid !== 1'b1);
      d = axiRsp.rdata;
      r = axiRsp.rresp;
      axiReq.rready <= 1'b0;
   endtask
   task automatic bark();
      @(posedge sys_clk);
      wdTo <= 1'b1;
      @(posedge sys_clk);
      wdTo <= 1'b0;
      @(posedge sys_clk);
      #1;
   endtask
   task automatic settle(input logic [1:0] f, input mrs_cause_t c,
      input logic [31:0] a = expA);
      n = 0;
      while (sysRstN !== 1'b1) begin
         @(posedge sys_clk);
         n++;
      end
      check("startup", n >= 1024, 1);
      check("img1", seenA, a);
      check("img2", seenB, expB);
      check("pcsp", seenC, 0);
      check("flags", flags, f);
      check("cause", cause, c);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", numChecks, mismatches);
      if (mismatches == 0 && numChecks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         mismatches++;
         finish_test();
      end
   end
   initial begin
      repeat (12) @(posedge sys_clk);
      nrst <= 1'b1;
      settle(2'b00, CS_POWERON);
      rd(`MRS_STATUS_OFS);
      check("status", d[1:0], 0);
      rd(8'h40);
      check("unmapped", r, `MRS_RESP_SLVERR);
      wr(`MRS_CORE_OFS, 32'h7FF);
      check("rdonly", r, `MRS_RESP_OKAY);
      check("pcsp", seenC, 0);
      $display("test power-on done");
      wr(`MRS_PORT_OFS, 32'h5A3C);
      i_sup.press(4);
      check("pin", sysRstN, 0);
      settle(2'b00, CS_PIN);
      $display("test pin done");
      wr(`MRS_WDSETUP_OFS, 32'h33);
      bark();
      check("wdrun", sysRstN, 0);
      settle(2'b10, CS_WDRUN);
      wr(`MRS_STATUS_OFS, 32'h3);
      check("w1c", flags, 0);
      $display("test watchdog run done");
      wr(`MRS_PORT_OFS, 32'h5A3C);
      wr(`MRS_WDSETUP_OFS, 32'h33);
      halt <= 1'b1;
      bark();
      check("pdflags", flags, 3);
      check("keep", seenA, 32'h3C5A0833);
      check("pcsp", seenC, 0);
      @(posedge sys_clk);
      halt <= 1'b0;
      settle(2'b11, CS_WDSLEEP, 32'h3C5A0833);
      $display("test watchdog halted done");
      i_sup.droop(10);
      repeat (3) @(posedge sys_clk);
      check("short", sysRstN, 1);
      i_sup.droop(30);
      repeat (3) @(posedge sys_clk);
      check("long", sysRstN, 0);
      settle(2'b11, CS_DROOP);
      wr(`MRS_CTRL_OFS, 32'h6);
      check("trip", trip, 3);
      i_sup.droop(30);
      repeat (3) @(posedge sys_clk);
      check("off", sysRstN, 1);
      $display("test droop done");
      finish_test();
   end
endmodule // mrs_reset_ctrl_tb_top
